// *** verilog/mbpc_pkg.sv ***
// shared constants and types for the muxed bus and power control block
`default_nettype none
package mbpc_pkg;
  // clock rate of sys_clk_in
  localparam int CLK_KHZ = 125000;
  localparam int CLK_PERIOD_NS = 8;
  // recovery interval after supply returns, legal window 20 to 150 ms
  localparam int REC_MIN_MS = 20;
  localparam int REC_MAX_MS = 150;
  // least time counts up, so the lower bound of the window is the target
  localparam int REC_CYCLES = REC_MIN_MS * CLK_KHZ;
  // output data delay from read strobe low, least time rounded up
  localparam int RD_DELAY_NS = 20;
  localparam int RD_DELAY_CYCLES = (RD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RD_DELAY_CNT = 4'(RD_DELAY_CYCLES);
  // register file geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 16;
  localparam int IDX_W = 4;
  localparam logic [ADDR_W-1:0] REG_LIMIT = 8'h10;
  // control register and its fields
  localparam logic [IDX_W-1:0] CTRL_IDX = 4'h0;
  localparam int CTRL_PWR_BIT = 0;
  localparam int CTRL_OSC_EN_BIT = 1;
  localparam int CTRL_CHAIN_RST_BIT = 2;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h03;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
  // bus strobes sampled from the pins
  typedef struct packed {
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } mbpc_strobe_t;
  // read side phases
  typedef enum logic [1:0] {
    MBPC_RD_IDLE,
    MBPC_RD_WAIT,
    MBPC_RD_DRIVE
  } mbpc_rd_state_t;
endpackage
`default_nettype wire

// *** verilog/mbpc_recovery.sv ***
// power-up recovery timer that locks out host accesses
`timescale 1ns/1ps
`default_nettype none
module mbpc_recovery #(
  parameter int REC_CYCLES = mbpc_pkg::REC_CYCLES
) (
  input wire logic sys_clk_in, // system clock
  input wire logic reset_in, // synchronous reset, active high
  input wire logic start_in, // pulse: supply has just returned
  input wire logic bypass_in, // level: oscillator off or chain in reset
  input wire logic supply_ok_in, // level: main supply present
  output logic done_out // level: accesses allowed
);
  logic [31:0] count_r;
  logic busy_r;

  // countdown runs only while supply stays; a bypass ends it at once
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      busy_r <= 1'b0;
      count_r <= 32'h0;
    end else if (!supply_ok_in) begin
      busy_r <= 1'b0;
      count_r <= 32'h0;
    end else if (start_in && !bypass_in) begin
      busy_r <= 1'b1;
      count_r <= 32'(REC_CYCLES - 1);
    end else if (busy_r && (bypass_in || count_r == 32'h0)) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      count_r <= count_r - 32'h1;
    end
  end

  // done is registered; one cycle of extra lockout is harmless against 20 ms
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= supply_ok_in && !busy_r && !(start_in && !bypass_in);
    end
  end
endmodule
`default_nettype wire

// *** verilog/mbpc_top.sv ***
// device end of the multiplexed address/data bus with power control output
//
// Behaviour
// - after supply returns, refuse accesses 20 ms; skip when oscillator off or chain reset
// - without main supply, kickstart falling edge or wake interrupt asserts power control
// - with supply present, power control level follows the software control bit
// - address is captured from the shared bus at the falling edge of ale
// - write data is captured at the rising edge of the write strobe
// - read data is driven onto the bus during the later part of read low
// - the bus is released to high impedance when the read strobe rises
// - chip select must cover the strobes; without it addresses latch, no access
`timescale 1ns/1ps
`default_nettype none
module mbpc_top #(
  parameter int REC_CYCLES = mbpc_pkg::REC_CYCLES
) (
  input wire logic sys_clk_in, // system clock, 125 MHz
  input wire logic reset_in, // synchronous reset, active high
  input wire mbpc_pkg::mbpc_strobe_t strobe_in, // ale, cs_n, rd_n, wr_n
  input wire logic [mbpc_pkg::DATA_W-1:0] muxed_addr_data_bus_in, // shared bus level
  output logic [mbpc_pkg::DATA_W-1:0] muxed_addr_data_bus_out, // read data
  output logic muxed_addr_data_bus_oe_out, // high while driving read data
  input wire logic supply_ok_in, // main supply present
  input wire logic kickstart_in_n, // kickstart input, active low
  input wire logic wake_irq_in, // wake-up interrupt request
  output logic system_power_on_n_out, // power control, only ever low
  output logic system_power_on_n_oe_out, // high while pulling power control low
  output logic access_ok_out // accesses currently allowed
);
  mbpc_pkg::mbpc_strobe_t strobe_prev_r;
  logic [mbpc_pkg::ADDR_W-1:0] addr_r;
  logic [mbpc_pkg::DATA_W-1:0] regs_r [mbpc_pkg::NUM_REGS];
  logic [mbpc_pkg::DATA_W-1:0] rd_data_nxt;
  mbpc_pkg::mbpc_rd_state_t rd_state_r;
  logic [3:0] rd_cnt_r;
  logic supply_prev_r;
  logic kick_prev_r;
  logic pwr_on_r;
  logic rec_done;
  logic ale_fall;
  logic wr_rise;
  logic wr_hit;
  logic rd_active;
  logic supply_rise;
  logic kick_fall;
  logic rec_bypass;
  logic [mbpc_pkg::DATA_W-1:0] data_hold_r;

  // an address inside the register file
  function automatic logic reg_hit(input logic [mbpc_pkg::ADDR_W-1:0] a);
    reg_hit = (a < mbpc_pkg::REG_LIMIT);
  endfunction

  // register index from a latched address
  function automatic logic [mbpc_pkg::IDX_W-1:0] reg_idx(input logic [mbpc_pkg::ADDR_W-1:0] a);
    reg_idx = a[mbpc_pkg::IDX_W-1:0];
  endfunction

  // previous strobe and pin levels for edge detection
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      strobe_prev_r <= '{ale: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
      supply_prev_r <= 1'b0;
      kick_prev_r <= 1'b1;
    end else begin
      strobe_prev_r <= strobe_in;
      supply_prev_r <= supply_ok_in;
      kick_prev_r <= kickstart_in_n;
    end
  end

  // edge terms; chip select is judged as it stood during the strobe
  assign ale_fall = strobe_prev_r.ale && !strobe_in.ale;
  assign wr_rise = !strobe_prev_r.wr_n && strobe_in.wr_n;
  assign wr_hit = wr_rise && !strobe_prev_r.cs_n && access_ok_out && reg_hit(addr_r);
  assign rd_active = !strobe_in.rd_n && !strobe_in.cs_n && access_ok_out;
  assign supply_rise = supply_ok_in && !supply_prev_r;
  assign kick_fall = kick_prev_r && !kickstart_in_n;

  // oscillator off or countdown chain held in reset skip the lockout
  assign rec_bypass = !regs_r[mbpc_pkg::CTRL_IDX][mbpc_pkg::CTRL_OSC_EN_BIT]
                      || regs_r[mbpc_pkg::CTRL_IDX][mbpc_pkg::CTRL_CHAIN_RST_BIT];

  mbpc_recovery #(
    .REC_CYCLES(REC_CYCLES)
  ) u_recovery (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .start_in(supply_rise),
    .bypass_in(rec_bypass),
    .supply_ok_in(supply_ok_in),
    .done_out(rec_done)
  );

  // accesses are refused without supply and during recovery
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      access_ok_out <= 1'b0;
    end else begin
      access_ok_out <= rec_done && supply_ok_in && !supply_rise;
    end
  end

  // address latch; chip select does not gate it
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      addr_r <= '0;
    end else if (ale_fall) begin
      addr_r <= muxed_addr_data_bus_in;
    end
  end

  // register file; data is taken as it stood just before the write strobe rose,
  // since write-data hold may be zero
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < mbpc_pkg::NUM_REGS; i++) begin
        regs_r[i] <= mbpc_pkg::REG_RESET;
      end
      regs_r[mbpc_pkg::CTRL_IDX] <= mbpc_pkg::CTRL_RESET;
    end else begin
      if (wr_hit) begin
        regs_r[reg_idx(addr_r)] <= data_hold_r;
      end
      // a wake source without supply sets the hold bit; set beats a clear
      if (!supply_ok_in && (kick_fall || wake_irq_in)) begin
        regs_r[mbpc_pkg::CTRL_IDX][mbpc_pkg::CTRL_PWR_BIT] <= 1'b1;
      end
    end
  end

  // bus level from the previous cycle, used as write data
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      data_hold_r <= '0;
    end else begin
      data_hold_r <= muxed_addr_data_bus_in;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_data_nxt = mbpc_pkg::UNMAPPED_READ;
    if (reg_hit(addr_r)) begin
      rd_data_nxt = regs_r[reg_idx(addr_r)];
    end
  end

  // read sequencer: wait out the output delay, drive, release on strobe rise
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rd_state_r <= mbpc_pkg::MBPC_RD_IDLE;
      rd_cnt_r <= 4'h0;
    end else begin
      case (rd_state_r)
        mbpc_pkg::MBPC_RD_IDLE: begin
          if (rd_active) begin
            rd_state_r <= mbpc_pkg::MBPC_RD_WAIT;
            rd_cnt_r <= 4'h1;
          end
        end
        mbpc_pkg::MBPC_RD_WAIT: begin
          if (!rd_active) begin
            rd_state_r <= mbpc_pkg::MBPC_RD_IDLE;
          end else if (rd_cnt_r >= mbpc_pkg::RD_DELAY_CNT - 4'h1) begin
            rd_state_r <= mbpc_pkg::MBPC_RD_DRIVE;
          end else begin
            rd_cnt_r <= rd_cnt_r + 4'h1;
          end
        end
        mbpc_pkg::MBPC_RD_DRIVE: begin
          if (!rd_active) begin
            rd_state_r <= mbpc_pkg::MBPC_RD_IDLE;
          end
        end
        default: begin
          rd_state_r <= mbpc_pkg::MBPC_RD_IDLE;
        end
      endcase
    end
  end

  // bus drivers registered so the pins come straight from flip-flops
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      muxed_addr_data_bus_oe_out <= 1'b0;
      muxed_addr_data_bus_out <= '0;
    end else begin
      muxed_addr_data_bus_oe_out <= rd_active && (rd_state_r == mbpc_pkg::MBPC_RD_DRIVE
                                    || (rd_state_r == mbpc_pkg::MBPC_RD_WAIT
                                    && rd_cnt_r >= mbpc_pkg::RD_DELAY_CNT - 4'h1));
      muxed_addr_data_bus_out <= rd_data_nxt;
    end
  end

  // power control: wake sources without supply, software bit with supply
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pwr_on_r <= 1'b0;
    end else if (!supply_ok_in) begin
      if (kick_fall || wake_irq_in) begin
        pwr_on_r <= 1'b1;
      end
    end else begin
      pwr_on_r <= regs_r[mbpc_pkg::CTRL_IDX][mbpc_pkg::CTRL_PWR_BIT];
    end
  end

  // open drain: value always low, enable carries the assertion; pullup gives high
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      system_power_on_n_out <= 1'b0;
      system_power_on_n_oe_out <= 1'b0;
    end else begin
      system_power_on_n_out <= 1'b0;
      system_power_on_n_oe_out <= pwr_on_r;
    end
  end
endmodule
`default_nettype wire

// *** verilog/mbpc_top_check_note.sv ***
// no logic here; the port checks of the block sit with the verification files

// *** verif/mbpc_top_properties.sv ***
// concurrent checks on the ports of the muxed bus and power control block
`timescale 1ns/1ps
`default_nettype none
module mbpc_top_properties #(
  parameter int REC_CYCLES = 50
) (
  input wire logic sys_clk_in, // system clock
  input wire logic reset_in, // synchronous reset
  input wire mbpc_pkg::mbpc_strobe_t strobe_in, // bus strobes
  input wire logic [mbpc_pkg::DATA_W-1:0] muxed_addr_data_bus_out, // read data
  input wire logic muxed_addr_data_bus_oe_out, // read drive
  input wire logic supply_ok_in, // supply present
  input wire logic kickstart_in_n, // kickstart
  input wire logic wake_irq_in, // wake request
  input wire logic system_power_on_n_out, // power level
  input wire logic system_power_on_n_oe_out, // power drive
  input wire logic access_ok_out // access allowed
);
  logic rd_act;
  // a selected read strobe the device may answer
  assign rd_act = !strobe_in.rd_n && !strobe_in.cs_n && access_ok_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  rd_late_a: assert property ($rose(rd_act) |=> !muxed_addr_data_bus_oe_out)
    else $error("read data driven too early");
  rd_drive_a: assert property ($rose(rd_act) ##1 rd_act [*4] |-> muxed_addr_data_bus_oe_out)
    else $error("read data not driven");
  rd_hold_a: assert property ($past(muxed_addr_data_bus_oe_out) && muxed_addr_data_bus_oe_out
    |-> $stable(muxed_addr_data_bus_out)) else $error("read data moved");
  rd_release_a: assert property (strobe_in.rd_n |=> !muxed_addr_data_bus_oe_out)
    else $error("bus held after read end");
  rd_select_a: assert property (strobe_in.cs_n |=> !muxed_addr_data_bus_oe_out)
    else $error("bus driven while deselected");
  lock_bus_a: assert property (!access_ok_out |=> !muxed_addr_data_bus_oe_out)
    else $error("bus driven during lockout");
  pwr_level_a: assert property (system_power_on_n_out == 1'b0)
    else $error("power pin driven high");
  kick_pwr_a: assert property (!supply_ok_in && $fell(kickstart_in_n) ##1 !supply_ok_in
    |-> ##[0:1] system_power_on_n_oe_out) else $error("kickstart ignored");
  wake_pwr_a: assert property (!supply_ok_in && wake_irq_in ##1 !supply_ok_in
    |-> ##[0:1] system_power_on_n_oe_out) else $error("wake ignored");
endmodule
`default_nettype wire

// *** verif/mbpc_host.sv ***
// host processor model driving the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module mbpc_host (
  input wire logic clk_in, // system clock
  input wire logic [7:0] dout_in, // device read data
  input wire logic oe_in, // device drives bus
  output var mbpc_pkg::mbpc_strobe_t st_out, // strobes
  output logic [7:0] bus_out // resolved bus level
);
  logic drv_r = 1'b0;
  logic [7:0] val_r = 8'h00;
  logic [7:0] pat_r = 8'h5a;
  logic [7:0] exp_q[$];
  initial st_out = 4'h7;
  // a released bus shows a moving pattern so a stale value never matches
  always @(posedge clk_in) pat_r <= pat_r + 8'h3b;
  assign bus_out = oe_in ? dout_in : drv_r ? val_r : pat_r;
  // address phase, then a strobe held 16 cycles, well over the least pulse width
  task automatic cyc(input logic [7:0] a, d, input logic rd, cs);
    if (rd && cs) exp_q.push_back(d);
    @(posedge clk_in);
    st_out <= 4'hf;
    drv_r <= 1'b1;
    val_r <= a;
    @(posedge clk_in);
    st_out <= 4'h7;
    @(posedge clk_in);
    st_out <= {1'b0, !cs, !rd, rd};
    drv_r <= !rd;
    val_r <= d;
    repeat (16) @(posedge clk_in);
    st_out <= 4'h7;
    drv_r <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** verif/muxed_bus_power_control_test.sv ***
// self-checking bench for the muxed bus and power control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module muxed_bus_power_control_test;
  localparam int REC = 50;
  logic clk = 0, rst = 1, sup = 1, ks_n = 1, wake = 0, oe, poe, pl, ok, oe_q = 0;
  logic [7:0] bus, dout, a, d, e_v;
  mbpc_pkg::mbpc_strobe_t st;
  int num_errors = 0, total_checks = 0, n;
  mbpc_top #(.REC_CYCLES(REC)) dut_u (.sys_clk_in(clk), .reset_in(rst), .strobe_in(st),
    .muxed_addr_data_bus_in(bus), .muxed_addr_data_bus_out(dout), .muxed_addr_data_bus_oe_out(oe),
    .supply_ok_in(sup), .kickstart_in_n(ks_n), .wake_irq_in(wake), .system_power_on_n_out(pl),
    .system_power_on_n_oe_out(poe), .access_ok_out(ok));
  mbpc_host host_u (.clk_in(clk), .dout_in(dout), .oe_in(oe), .st_out(st), .bus_out(bus));
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for the lockout to end, n holds the cycles spent
  task automatic wait_ok();
    n = 0;
    while (ok !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    `CHK(ok, 1'b1)
  endtask
  initial forever #4 clk = ~clk;
  // each fresh read drive is matched against the oldest expected byte
  always @(posedge clk) begin
    oe_q <= oe;
    if (oe === 1'b1 && oe_q !== 1'b1) begin
      // a drive with nothing pending is a mismatch by itself, so an unknown cannot slip by
      if (host_u.exp_q.size() == 0) begin
        num_errors++;
        $display("FAIL %0t read drive with no read pending", $time);
      end else begin
        e_v = host_u.exp_q.pop_front();
        `CHK(dout, e_v)
      end
    end
  end
  // whole run is about 650 cycles, so 5000 only trips on a hang
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(59486));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(ok, 1'b0)
    wait_ok();
    `CHK(n >= REC - 1 && n <= REC + 6, 1'b1)
    $display("test lockout done");
    host_u.cyc(8'h00, mbpc_pkg::CTRL_RESET, 1, 1);
    for (int i = 0; i < 6; i++) begin
      a = 8'(1 + $urandom % 15);
      d = 8'($urandom);
      host_u.cyc(a, d, 0, 1);
      host_u.cyc(a, d, 1, 1);
    end
    // deselected cycles change nothing; unmapped reads give zero
    host_u.cyc(a, ~d, 0, 0);
    host_u.cyc(a, 8'h00, 1, 0);
    host_u.cyc(a, d, 1, 1);
    host_u.cyc(8'h80, mbpc_pkg::UNMAPPED_READ, 1, 1);
    $display("test bus done");
    host_u.cyc(8'h00, 8'h02, 0, 1); // oscillator kept enabled, a 32.768 kHz reference is taken as fitted
    repeat (3) @(posedge clk);
    `CHK(poe, 1'b0)
    `CHK(pl, 1'b0)
    // without supply, kickstart then wake must turn power on
    for (int k = 0; k < 2; k++) begin
      host_u.cyc(8'h00, 8'h02, 0, 1);
      sup <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(poe, 1'b0)
      if (k == 0) ks_n <= 1'b0;
      else wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(poe, 1'b1)
      ks_n <= 1'b1;
      sup <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(ok, 1'b0)
      // accesses inside the lockout: the write must not clear the hold bit, the read must not drive
      host_u.cyc(8'h00, 8'h02, 0, 1);
      host_u.cyc(8'h00, 8'h00, 1, 1);
      `CHK(host_u.exp_q.size(), 1)
      void'(host_u.exp_q.pop_back());
      wait_ok();
    end
    `CHK(poe, 1'b1)
    $display("test power done");
    // oscillator off, then chain held: access comes at once
    for (int k = 0; k < 2; k++) begin
      host_u.cyc(8'h00, k ? 8'h07 : 8'h01, 0, 1);
      sup <= 1'b0;
      repeat (3) @(posedge clk);
      sup <= 1'b1;
      @(posedge clk);
      wait_ok();
      `CHK(n < 6, 1'b1)
    end
    // every selected read in the lockout-free phases must have been answered
    `CHK(host_u.exp_q.size(), 0)
    $display("test bypass done");
    close_out();
  end
endmodule
bind mbpc_top mbpc_top_properties #(.REC_CYCLES(REC_CYCLES)) chk_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .strobe_in(strobe_in), .muxed_addr_data_bus_out(muxed_addr_data_bus_out),
  .muxed_addr_data_bus_oe_out(muxed_addr_data_bus_oe_out), .supply_ok_in(supply_ok_in),
  .kickstart_in_n(kickstart_in_n), .wake_irq_in(wake_irq_in), .system_power_on_n_out(system_power_on_n_out),
  .system_power_on_n_oe_out(system_power_on_n_oe_out), .access_ok_out(access_ok_out));
`default_nettype wire
